//--- iefp_ctrl.sv
// interrupt enable, priority and extended flag registers of the embedded cpu
// assumes a one-cycle sfr write strobe and a combinational-address read port
`timescale 1ns/1ns
`include "iefp_cfg.svh"
module iefp_ctrl (
  input wire logic sys_clk_in, // cpu clock, 125 MHz
  input wire logic reset_n_in, // async reset, active low
  input wire iefp_pkg::iefp_byte_t sfr_addr_in, // sfr address
  input wire logic sfr_write_in, // write strobe
  input wire iefp_pkg::iefp_byte_t sfr_wdata_in, // write data
  input wire logic sfr_read_in, // read strobe
  output iefp_pkg::iefp_byte_t sfr_rdata_out, // read data, one cycle after strobe
  output logic sfr_hit_out, // read address belongs to this block
  input wire logic timer0_overflow_flag_in, // timer0 flag
  input wire logic timer1_overflow_flag_in, // timer1 flag
  input wire logic timer2_overflow_flag_in, // timer2 overflow flag
  input wire logic timer2_external_flag_in, // timer2 external flag
  input wire logic serial_tx_done_flag_in, // serial transmit done
  input wire logic serial_rx_done_flag_in, // serial receive done
  input wire logic ext_pin0_req_in, // pin0 request flag, already sampled
  input wire logic ext_pin1_req_in, // pin1 request flag, already sampled
  input wire logic radio_addr_match_in, // radio address match level
  input wire logic radio_data_ready_in, // radio data ready level
  input wire logic spi_byte_done_in, // spi byte done pulse
  input wire logic conv_end_in, // converter end-of-conversion level
  input wire logic wakeup_event_in, // pin or timer wakeup pulse
  output iefp_pkg::iefp_src_vec_t irq_high_out, // pending high-level requests
  output iefp_pkg::iefp_src_vec_t irq_low_out // pending low-level requests
);
  import iefp_pkg::*;

  iefp_byte_t standard_interrupt_enable;
  iefp_byte_t standard_interrupt_priority;
  iefp_byte_t extended_interrupt_enable;
  iefp_byte_t extended_interrupt_priority;
  logic addr_match_flag;
  logic data_ready_flag;
  logic spi_byte_done_flag;
  logic conversion_end_flag;
  logic wakeup_flag;

  function automatic logic sel(input iefp_byte_t a, input iefp_byte_t ref_addr);
    sel = (a == ref_addr);
  endfunction

  wire wr_std_en = sfr_write_in & sel(sfr_addr_in, `IEFP_ADDR_STD_ENABLE);
  wire wr_std_pr = sfr_write_in & sel(sfr_addr_in, `IEFP_ADDR_STD_PRIO);
  wire wr_ext_fl = sfr_write_in & sel(sfr_addr_in, `IEFP_ADDR_EXT_FLAGS);
  wire wr_ext_ct = sfr_write_in & sel(sfr_addr_in, `IEFP_ADDR_EXT_CTRL);
  wire wr_ext_en = sfr_write_in & sel(sfr_addr_in, `IEFP_ADDR_EXT_ENABLE);
  wire wr_ext_pr = sfr_write_in & sel(sfr_addr_in, `IEFP_ADDR_EXT_PRIO);

  // extended flags: sticky, hardware never clears them
  iefp_edge_flag #(.EDGE_MODE(1'b1)) u_am (
    .clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .event_in(radio_addr_match_in),
    .write_in(wr_ext_fl),
    .write_value_in(sfr_wdata_in[`IEFP_BIT_ADDR_MATCH]),
    .flag_out(addr_match_flag)
  );
  iefp_edge_flag #(.EDGE_MODE(1'b1)) u_dr (
    .clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .event_in(radio_data_ready_in),
    .write_in(wr_ext_fl),
    .write_value_in(sfr_wdata_in[`IEFP_BIT_DATA_READY]),
    .flag_out(data_ready_flag)
  );
  // byte-done arrives as a pulse, so no edge detection
  iefp_edge_flag #(.EDGE_MODE(1'b0)) u_spi (
    .clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .event_in(spi_byte_done_in),
    .write_in(wr_ext_fl),
    .write_value_in(sfr_wdata_in[`IEFP_BIT_SPI_DONE]),
    .flag_out(spi_byte_done_flag)
  );
  iefp_edge_flag #(.EDGE_MODE(1'b1)) u_eoc (
    .clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .event_in(conv_end_in),
    .write_in(wr_ext_fl),
    .write_value_in(sfr_wdata_in[`IEFP_BIT_CONV_END]),
    .flag_out(conversion_end_flag)
  );
  // wakeup flag left set re-requests after return
  iefp_edge_flag #(.EDGE_MODE(1'b0)) u_wake (
    .clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .event_in(wakeup_event_in),
    .write_in(wr_ext_ct),
    .write_value_in(sfr_wdata_in[`IEFP_BIT_WAKEUP]),
    .flag_out(wakeup_flag)
  );

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      standard_interrupt_enable <= `IEFP_RESET_BYTE;
      standard_interrupt_priority <= `IEFP_RESET_BYTE;
      extended_interrupt_enable <= `IEFP_RESET_BYTE;
      extended_interrupt_priority <= `IEFP_RESET_BYTE;
    end else begin
      if (wr_std_en) begin
        standard_interrupt_enable <= sfr_wdata_in & `IEFP_STD_ENABLE_MASK;
      end
      if (wr_std_pr) begin
        standard_interrupt_priority <= sfr_wdata_in & `IEFP_STD_PRIO_MASK;
      end
      if (wr_ext_en) begin
        extended_interrupt_enable <= sfr_wdata_in & `IEFP_EXT_EN_MASK;
      end
      if (wr_ext_pr) begin
        extended_interrupt_priority <= sfr_wdata_in & `IEFP_EXT_EN_MASK;
      end
    end
  end

  wire global_irq_enable = standard_interrupt_enable[`IEFP_BIT_GLOBAL];

  // source order: 0 pin0, 1 timer0, 2 pin1, 3 timer1, 4 serial, 5 timer2,
  // 6 conv end, 7 spi, 8 data ready, 9 addr match, 10 wakeup
  wire [10:0] src_flag = {wakeup_flag, addr_match_flag, data_ready_flag,
    spi_byte_done_flag, conversion_end_flag,
    timer2_overflow_flag_in | timer2_external_flag_in,
    serial_tx_done_flag_in | serial_rx_done_flag_in,
    timer1_overflow_flag_in,
    ext_pin1_req_in,
    timer0_overflow_flag_in,
    ext_pin0_req_in};
  wire [10:0] src_enable = {extended_interrupt_enable[4:0], standard_interrupt_enable[5:0]};
  wire [10:0] src_prio = {extended_interrupt_priority[4:0], standard_interrupt_priority[5:0]};
  wire [10:0] next_high;
  wire [10:0] next_low;

  iefp_src_gate #(.NUM_SRC(11)) u_gate (
    .global_in(global_irq_enable),
    .flag_in(src_flag),
    .enable_in(src_enable),
    .prio_in(src_prio),
    .high_out(next_high),
    .low_out(next_low)
  );

  wire [7:0] ext_flags_view = {addr_match_flag, data_ready_flag, spi_byte_done_flag,
    conversion_end_flag, 4'h0} | `IEFP_EXT_FLAGS_ONES;
  wire [7:0] ext_ctrl_view = {4'h0, wakeup_flag, 3'h0} | `IEFP_EXT_CTRL_ONES;
  wire hit = sel(sfr_addr_in, `IEFP_ADDR_EXT_FLAGS) | sel(sfr_addr_in, `IEFP_ADDR_STD_ENABLE)
    | sel(sfr_addr_in, `IEFP_ADDR_STD_PRIO) | sel(sfr_addr_in, `IEFP_ADDR_EXT_CTRL)
    | sel(sfr_addr_in, `IEFP_ADDR_EXT_ENABLE) | sel(sfr_addr_in, `IEFP_ADDR_EXT_PRIO);
  wire [7:0] next_rdata =
    sel(sfr_addr_in, `IEFP_ADDR_EXT_FLAGS) ? ext_flags_view :
    sel(sfr_addr_in, `IEFP_ADDR_STD_ENABLE) ? standard_interrupt_enable :
    sel(sfr_addr_in, `IEFP_ADDR_STD_PRIO) ? (standard_interrupt_priority | `IEFP_STD_PRIO_ONES) :
    sel(sfr_addr_in, `IEFP_ADDR_EXT_CTRL) ? ext_ctrl_view :
    sel(sfr_addr_in, `IEFP_ADDR_EXT_ENABLE) ? (extended_interrupt_enable | `IEFP_EXT_EN_ONES) :
    sel(sfr_addr_in, `IEFP_ADDR_EXT_PRIO) ? (extended_interrupt_priority | `IEFP_EXT_EN_ONES) :
    8'h00;

  // registered outputs add one cycle; cpu samples once per instruction anyway
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_high_out <= 11'h000;
      irq_low_out <= 11'h000;
      sfr_rdata_out <= 8'h00;
      sfr_hit_out <= 1'b0;
    end else begin
      irq_high_out <= next_high;
      irq_low_out <= next_low;
      sfr_rdata_out <= sfr_read_in ? next_rdata : 8'h00;
      sfr_hit_out <= sfr_read_in & hit;
    end
  end
endmodule

//--- iefp_cfg.svh
// register offsets, field positions, reset values and read-as masks of the interrupt control block
// assumes an 8-bit special-function-register space reached by the cpu core
`ifndef IEFP_CFG_SVH
`define IEFP_CFG_SVH
`define IEFP_ADDR_EXT_FLAGS 8'h91
`define IEFP_ADDR_STD_ENABLE 8'hA8
`define IEFP_ADDR_STD_PRIO 8'hB8
`define IEFP_ADDR_EXT_CTRL 8'hD8
`define IEFP_ADDR_EXT_ENABLE 8'hE8
`define IEFP_ADDR_EXT_PRIO 8'hF8
// standard enable and priority fields
`define IEFP_BIT_GLOBAL 7
`define IEFP_STD_ENABLE_MASK 8'hBF
`define IEFP_STD_PRIO_MASK 8'h3F
`define IEFP_STD_PRIO_ONES 8'h80
// extended flags: bits 7..4 hold interrupts 9..6
`define IEFP_BIT_ADDR_MATCH 7
`define IEFP_BIT_DATA_READY 6
`define IEFP_BIT_SPI_DONE 5
`define IEFP_BIT_CONV_END 4
`define IEFP_EXT_FLAGS_ONES 8'h08
`define IEFP_BIT_WAKEUP 3
`define IEFP_EXT_CTRL_ONES 8'h40
`define IEFP_EXT_EN_MASK 8'h1F
`define IEFP_EXT_EN_ONES 8'hE0
`define IEFP_RESET_BYTE 8'h00
`endif

//--- iefp_pkg.sv
// types shared by the interrupt control block
// assumes nothing beyond a SystemVerilog compiler
package iefp_pkg;
  typedef logic [7:0] iefp_byte_t;
  typedef logic [10:0] iefp_src_vec_t;
endpackage

//--- iefp_edge_flag.sv
// one sticky interrupt flag set by a rising edge, a pulse or a software write of one
// assumes event inputs are synchronous to the clock
`timescale 1ns/1ns
module iefp_edge_flag #(
  parameter bit EDGE_MODE = 1'b1
) (
  input wire logic clk_in, // system clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic event_in, // hardware event level or pulse
  input wire logic write_in, // software write strobe for this flag
  input wire logic write_value_in, // value written
  output logic flag_out // sticky flag
);
  logic event_prev;
  wire hw_set = EDGE_MODE ? (event_in & ~event_prev) : event_in;
  // hardware set beats a software clear in the same cycle
  wire next_flag = hw_set | (write_in ? write_value_in : flag_out);
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      event_prev <= 1'b0;
      flag_out <= 1'b0;
    end else begin
      event_prev <= event_in;
      flag_out <= next_flag;
    end
  end
endmodule

//--- iefp_src_gate.sv
// per-source gating of the eleven interrupt sources into pending requests and levels
// assumes enables and flags are already registered
`timescale 1ns/1ns
module iefp_src_gate #(
  parameter int NUM_SRC = 11
) (
  input wire logic global_in, // global enable
  input wire logic [NUM_SRC-1:0] flag_in, // per-source request
  input wire logic [NUM_SRC-1:0] enable_in, // per-source enable
  input wire logic [NUM_SRC-1:0] prio_in, // per-source high priority
  output logic [NUM_SRC-1:0] high_out, // pending, high level
  output logic [NUM_SRC-1:0] low_out // pending, low level
);
  // refused while elaborating, so a bad count never reaches simulation
  if (NUM_SRC < 1) begin : g_bad_count
    $error("iefp_src_gate needs at least one source");
  end
  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i++) begin : g_src
      wire pend = global_in & enable_in[i] & flag_in[i];
      assign high_out[i] = pend & prio_in[i];
      assign low_out[i] = pend & ~prio_in[i];
    end
  endgenerate
endmodule

//--- iefp_ctrl_props.sv
// port assertions of the interrupt control block
// assumes it is bound to iefp_ctrl below
`timescale 1ns/1ns
module iefp_ctrl_chk (
  input wire logic sys_clk_in, // clock
  input wire logic reset_n_in, // reset, active low
  input wire iefp_pkg::iefp_byte_t sfr_addr_in, // address
  input wire logic sfr_write_in, // write
  input wire iefp_pkg::iefp_byte_t sfr_wdata_in, // write data
  input wire logic sfr_read_in, // read
  input wire iefp_pkg::iefp_byte_t sfr_rdata_out, // read data
  input wire logic sfr_hit_out, // read hit
  input wire logic radio_addr_match_in, // match level
  input wire iefp_pkg::iefp_src_vec_t irq_high_out, // high pending
  input wire iefp_pkg::iefp_src_vec_t irq_low_out // low pending
);
  import iefp_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence rd_at(a);
    sfr_read_in && sfr_addr_in == a;
  endsequence
  sequence am_edge;
    $rose(radio_addr_match_in);
  endsequence
  chk_level_split: assert property ((irq_high_out & irq_low_out) == 11'h000)
    else $error("source pending at both levels");
  chk_unmapped_read: assert property (sfr_read_in && !(sfr_addr_in inside {8'h91, 8'hA8,
    8'hB8, 8'hD8, 8'hE8, 8'hF8}) |=> !sfr_hit_out && sfr_rdata_out == 8'h00)
    else $error("unmapped read answered");
  chk_enable_read: assert property (rd_at(8'hA8) |=> sfr_hit_out && !sfr_rdata_out[6])
    else $error("enable read view wrong");
  chk_prio_read: assert property (rd_at(8'hB8) |=> sfr_rdata_out[7:6] == 2'h2)
    else $error("priority read view wrong");
  chk_flags_read: assert property (rd_at(8'h91) |=> sfr_rdata_out[3:0] == 4'h8)
    else $error("flag read view wrong");
  chk_ctrl_read: assert property (rd_at(8'hD8) |=> (sfr_rdata_out & 8'hF7) == 8'h40)
    else $error("control read view wrong");
  chk_ext_read: assert property (sfr_read_in && (sfr_addr_in == 8'hE8 ||
    sfr_addr_in == 8'hF8) |=> sfr_rdata_out[7:5] == 3'h7)
    else $error("extended read view wrong");
  chk_global_mask: assert property (sfr_write_in && sfr_addr_in == 8'hA8 &&
    !sfr_wdata_in[7] |-> ##2 (irq_high_out | irq_low_out) == 11'h000)
    else $error("request passed with global off");
  // read one cycle after the edge: a later clearing write would be legal
  chk_match_flag: assert property (am_edge ##1 rd_at(8'h91) |=> sfr_rdata_out[7])
    else $error("match edge did not set flag");
endmodule
bind iefp_ctrl iefp_ctrl_chk chk_u (
  .sys_clk_in(sys_clk_in),
  .reset_n_in(reset_n_in),
  .sfr_addr_in(sfr_addr_in),
  .sfr_write_in(sfr_write_in),
  .sfr_wdata_in(sfr_wdata_in),
  .sfr_read_in(sfr_read_in),
  .sfr_rdata_out(sfr_rdata_out),
  .sfr_hit_out(sfr_hit_out),
  .radio_addr_match_in(radio_addr_match_in),
  .irq_high_out(irq_high_out),
  .irq_low_out(irq_low_out)
);

//--- iefp_src_model.sv
// model of the peripherals raising the interrupt sources
// assumes requests change just after a rising edge
`timescale 1ns/1ns
module iefp_src_model (
  input wire logic clk_in, // cpu clock
  input wire logic reset_n_in, // reset, active low
  input wire logic [7:0] std_req_in, // standard flag levels wanted
  input wire logic [4:0] ext_req_in, // conv, spi, ready, match, wakeup
  output logic [7:0] std_flags_out, // standard flag levels
  output logic [4:0] ext_ev_out // extended events
);
  logic [4:0] lvl;
  logic [4:0] prev;
  // spi and wakeup give one-cycle pulses, the rest hold levels
  assign ext_ev_out = lvl & ~(prev & 5'h12);
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      std_flags_out <= 8'h00;
      lvl <= 5'h00;
      prev <= 5'h00;
    end else begin
      std_flags_out <= std_req_in;
      lvl <= ext_req_in;
      prev <= lvl;
    end
  end
endmodule

//--- tb.sv
// self-checking bench of the interrupt control block
// assumes the source model and bound checker are compiled first
`timescale 1ns/1ns
module tb;
  import iefp_pkg::*;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  iefp_byte_t sfr_addr_in = 8'h00;
  iefp_byte_t sfr_wdata_in = 8'h00;
  logic sfr_write_in = 1'b0;
  logic sfr_read_in = 1'b0;
  logic rd_pend = 1'b0;
  logic irq_pend = 1'b0;
  logic [7:0] std_req = 8'h00;
  logic [4:0] ext_req = 5'h00;
  logic [4:0] ev;
  logic [7:0] fl;
  iefp_byte_t sfr_rdata_out;
  logic sfr_hit_out;
  iefp_src_vec_t irq_high_out;
  iefp_src_vec_t irq_low_out;
  logic [21:0] eq[$];
  int bad_count = 0;
  int n_checks = 0;
  int seed = 26;
  always #4 sys_clk_in = ~sys_clk_in;
  iefp_src_model src_u (.clk_in(sys_clk_in), .reset_n_in(reset_n_in), .std_req_in(std_req),
    .ext_req_in(ext_req), .std_flags_out(fl), .ext_ev_out(ev));
  iefp_ctrl dut_u (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .sfr_addr_in(sfr_addr_in),
    .sfr_write_in(sfr_write_in), .sfr_wdata_in(sfr_wdata_in), .sfr_read_in(sfr_read_in),
    .sfr_rdata_out(sfr_rdata_out), .sfr_hit_out(sfr_hit_out), .ext_pin0_req_in(fl[0]),
    .timer0_overflow_flag_in(fl[1]), .ext_pin1_req_in(fl[2]), .timer1_overflow_flag_in(fl[3]),
    .serial_tx_done_flag_in(fl[4]), .serial_rx_done_flag_in(fl[5]),
    .timer2_overflow_flag_in(fl[6]), .timer2_external_flag_in(fl[7]),
    .conv_end_in(ev[0]), .spi_byte_done_in(ev[1]), .radio_data_ready_in(ev[2]),
    .radio_addr_match_in(ev[3]), .wakeup_event_in(ev[4]),
    .irq_high_out(irq_high_out), .irq_low_out(irq_low_out));
  task automatic check(input logic [21:0] seen, input logic [21:0] want);
    n_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input iefp_byte_t a, input iefp_byte_t d);
    @(posedge sys_clk_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_write_in <= 1'b1;
    @(posedge sys_clk_in);
    sfr_write_in <= 1'b0;
  endtask
  task automatic rd(input iefp_byte_t a, input logic [8:0] want);
    eq.push_back({13'h0000, want});
    @(posedge sys_clk_in);
    sfr_addr_in <= a;
    sfr_read_in <= 1'b1;
    @(posedge sys_clk_in);
    sfr_read_in <= 1'b0;
  endtask
  task automatic probe(input logic [21:0] want);
    eq.push_back(want);
    repeat (3) @(posedge sys_clk_in);
    irq_pend <= 1'b1;
    @(posedge sys_clk_in);
    irq_pend <= 1'b0;
  endtask
  always @(posedge sys_clk_in) rd_pend <= sfr_read_in;
  always @(negedge sys_clk_in) begin
    if (rd_pend) check({13'h0000, sfr_hit_out, sfr_rdata_out}, eq.pop_front());
    if (irq_pend) check({irq_high_out, irq_low_out}, eq.pop_front());
  end
  initial begin
    logic [7:0] en;
    logic [7:0] pr;
    logic [7:0] lv;
    logic [10:0] src;
    repeat (4) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      en = {i[0], 7'($random(seed))};
      pr = 8'($random(seed));
      lv = 8'($random(seed));
      std_req <= lv;
      wr(8'hA8, en);
      wr(8'hB8, pr);
      src = {5'h00, lv[7] | lv[6], lv[5] | lv[4], lv[3:0]} & {5'h00, en[5:0]} & {11{en[7]}};
      probe({src & {5'h00, pr[5:0]}, src & ~{5'h00, pr[5:0]}});
      rd(8'hA8, {1'b1, en & 8'hBF});
      rd(8'hB8, {1'b1, (pr & 8'h3F) | 8'h80});
      $display("standard pass %0d done", i);
    end
    std_req <= 8'h00;
    wr(8'hA8, 8'h80);
    wr(8'hE8, 8'h1F);
    wr(8'hF8, 8'h0A);
    ext_req <= 5'h1F;
    @(posedge sys_clk_in);
    rd(8'h91, 9'h1F8);
    rd(8'hD8, 9'h148);
    ext_req <= 5'h00;
    probe({5'h0A, 6'h00, 5'h15, 6'h00});
    rd(8'hE8, 9'h1FF);
    rd(8'hF8, 9'h1EA);
    wr(8'h91, 8'h00);
    wr(8'hD8, 8'h00);
    probe(22'h000000);
    wr(8'h91, 8'h50);
    wr(8'hD8, 8'h08);
    probe({11'h000, 5'h15, 6'h00});
    wr(8'hA8, 8'h3F);
    probe(22'h000000);
    // match edge lands with a clearing write: the set must win
    ext_req <= 5'h08;
    wr(8'h91, 8'h00);
    rd(8'h91, 9'h188);
    rd(8'h90, 9'h000);
    // let the last read be compared before the verdict
    repeat (2) @(posedge sys_clk_in);
    $display("extended pass done");
    end_of_test();
  end
  initial begin
    #40000;
    bad_count++;
    end_of_test();
  end
endmodule
